// *** hdl/etg_generator.sv ***
// Notes on behaviour
// - registers decode as base plus byte offset
// - one shared active-low reset clears everything
// - offset zero holds packets-per-run target
// - config bit 0: fixed or random length
// - config bits 14:1 give fixed frame size
// - config bit 15: incrementing or random payload
// - control bit 0 starts, self-clears on start
// - control bit 1 stops after current frame
// - control bit 2 done; cleared by start
// - low address words give four bytes
// - frame: addresses, type, sequence, payload, CRC
// - no preamble, delimiter or MAC check
// - 92-bit random source seeded from three words
// - sent counter at 0x24, cleared by start
`timescale 1ns/10ps
`default_nettype none
module etg_generator (
   input  wire logic        clk,           // design clock, 125 MHz
   input  wire logic        arst_n,        // async reset, active low
   input  wire logic [31:0] busAddr,       // register byte address
   input  wire logic        busWrite,      // write strobe
   input  wire logic [31:0] busWriteData,  // write data
   input  wire logic        busRead,       // read strobe
   output logic      [31:0] busReadData,   // read data
   output logic             busReadValid,  // read data valid pulse
   output logic      [7:0]  txData,        // frame byte
   output logic             txValid,       // byte valid
   output logic             txSop,         // first byte of frame
   output logic             txEop,         // last byte of frame
   input  wire logic        txReady        // MAC accepts byte
);

   typedef struct packed {
      logic [31:0]           pktTarget;
      logic [15:0]           cfg;
      logic                  startBit;
      logic                  stopBit;
      logic                  doneBit;
      logic [31:0]           srcLow;
      logic [15:0]           srcHigh;
      logic [31:0]           dstLow;
      logic [15:0]           dstHigh;
      logic [31:0]           sentCount;
      logic [31:0]           seedLow;
      logic [31:0]           seedMid;
      logic [31:0]           seedHigh;
      logic [31:0]           madeCount;
      etg_pkg::etg_state_type state;
      logic [13:0]           byteIdx;
      logic [13:0]           payloadLen;
      logic [15:0]           seqNum;
      logic [7:0]            incByte;
      logic [91:0]           prng;
      logic [31:0]           crc;
      logic [31:0]           readData;
      logic                  readValid;
      logic [7:0]            txData;
      logic                  txValid;
      logic                  txSop;
      logic                  txEop;
   } etg_regs_type;

   etg_regs_type r;
   etg_regs_type next_r;

   etg_stream_if #(.WIDTH(etg_pkg::WORD_BITS)) fillIf ();
   etg_stream_if #(.WIDTH(etg_pkg::WORD_BITS)) drainIf ();

   etg_fifo #(
      .WIDTH (etg_pkg::WORD_BITS),
      .DEPTH (etg_pkg::FIFO_DEPTH)
   ) etg_fifo_inst (
      .clk     (clk),
      .arst_n  (arst_n),
      .inPort  (fillIf),
      .outPort (drainIf)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // helper functions

   function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [7:0] b);
      logic [31:0] c;
      c = crc ^ {24'h000000, b};
      for (int i = 0; i < etg_pkg::BYTE_BITS; i++) begin
         c = c[0] ? ((c >> 1) ^ etg_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   function automatic logic [91:0] prngStep(input logic [91:0] p);
      logic [91:0] q;
      logic        fb;
      q = p;
      for (int i = 0; i < etg_pkg::BYTE_BITS; i++) begin
         fb = q[etg_pkg::PRNG_TAP0] ^ q[etg_pkg::PRNG_TAP1]
            ^ q[etg_pkg::PRNG_TAP2] ^ q[etg_pkg::PRNG_TAP3];
         q = {q[90:0], fb};
      end
      return q;
   endfunction

   // payload size for the next frame from the current mode
   function automatic logic [13:0] frameLen(input logic [15:0] cfg, input logic [91:0] p);
      logic [13:0] size;
      size = cfg[etg_pkg::CFG_SIZE_MSB:etg_pkg::CFG_SIZE_LSB];
      if (cfg[etg_pkg::CFG_LEN_SEL]) begin
         return {4'h0, p[etg_pkg::RAND_LEN_BITS-1:0]};
      end else if (size < etg_pkg::SIZE_OVERHEAD) begin
         return 14'h0000;
      end else begin
         return size - etg_pkg::SIZE_OVERHEAD;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // frame byte selection

   logic [47:0] dstMac;
   logic [47:0] srcMac;
   logic [15:0] typeField;
   logic [7:0]  headByte;
   logic [7:0]  bodyByte;
   logic [31:0] crcOut;
   logic [7:0]  curByte;
   logic        curSop;
   logic        curEop;
   logic        pushOk;
   logic        regHit;
   logic [5:0]  regOff;
   logic        lastFrame;

   assign dstMac    = {r.dstHigh, r.dstLow};
   assign srcMac    = {r.srcHigh, r.srcLow};
   assign typeField = {2'b00, r.payloadLen};
   assign crcOut    = ~r.crc;
   assign bodyByte  = r.cfg[etg_pkg::CFG_PATTERN] ? r.prng[7:0] : r.incByte;
   assign regHit    = (busAddr[31:etg_pkg::OFFSET_BITS] ==
                       etg_pkg::BASE_ADDR[31:etg_pkg::OFFSET_BITS]);
   assign regOff    = busAddr[etg_pkg::OFFSET_BITS-1:0];
   assign lastFrame = (r.madeCount + 32'h0000_0001) == r.pktTarget;

   // header order: destination, source, type, sequence
   always_comb begin
      if (r.byteIdx < 14'h0006) begin
         headByte = dstMac[8*r.byteIdx[2:0] +: 8];
      end else if (r.byteIdx < 14'h000C) begin
         headByte = srcMac[8*(r.byteIdx[3:0] - 4'h6) +: 8];
      end else if (r.byteIdx == 14'h000C) begin
         headByte = typeField[15:8];
      end else if (r.byteIdx == 14'h000D) begin
         headByte = typeField[7:0];
      end else if (r.byteIdx == 14'h000E) begin
         headByte = r.seqNum[15:8];
      end else begin
         headByte = r.seqNum[7:0];
      end
   end

   // no preamble or delimiter; frame opens with the destination address
   always_comb begin
      curSop = 1'b0;
      curEop = 1'b0;
      case (r.state)
         etg_pkg::ST_HEAD: begin
            curByte = headByte;
            curSop  = (r.byteIdx == 14'h0000);
         end
         etg_pkg::ST_BODY: begin
            curByte = bodyByte;
         end
         etg_pkg::ST_TAIL: begin
            curByte = crcOut[8*r.byteIdx[1:0] +: 8];
            curEop  = (r.byteIdx == etg_pkg::TAIL_LAST);
         end
         default: begin
            curByte = 8'h00;
         end
      endcase
   end

   assign fillIf.valid  = (r.state != etg_pkg::ST_IDLE);
   assign fillIf.data   = {curSop, curEop, curByte};
   assign pushOk        = fillIf.valid && fillIf.ready;
   assign drainIf.ready = !r.txValid || txReady;

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_r           = r;
      next_r.readValid = 1'b0;

      // register writes
      if (busWrite && regHit) begin
         if (regOff == etg_pkg::OFF_PKT_TARGET) begin
            next_r.pktTarget = busWriteData;
         end else if (regOff == etg_pkg::OFF_CONFIG) begin
            next_r.cfg = busWriteData[etg_pkg::CFG_WIDTH-1:0];
         end else if (regOff == etg_pkg::OFF_CONTROL) begin
            if (busWriteData[etg_pkg::CTL_START] && r.state == etg_pkg::ST_IDLE) begin
               next_r.startBit  = 1'b1;
               next_r.doneBit   = 1'b0;
               next_r.sentCount = etg_pkg::RESET_WORD;
            end
            if (busWriteData[etg_pkg::CTL_STOP] && r.state != etg_pkg::ST_IDLE) begin
               next_r.stopBit = 1'b1;
            end
         end else if (regOff == etg_pkg::OFF_SRC_LOW) begin
            next_r.srcLow = busWriteData;
         end else if (regOff == etg_pkg::OFF_SRC_HIGH) begin
            next_r.srcHigh = busWriteData[etg_pkg::MAC_HIGH_BITS-1:0];
         end else if (regOff == etg_pkg::OFF_DST_LOW) begin
            next_r.dstLow = busWriteData;
         end else if (regOff == etg_pkg::OFF_DST_HIGH) begin
            next_r.dstHigh = busWriteData[etg_pkg::MAC_HIGH_BITS-1:0];
         end else if (regOff == etg_pkg::OFF_SEED_LOW) begin
            next_r.seedLow = busWriteData;
         end else if (regOff == etg_pkg::OFF_SEED_MID) begin
            next_r.seedMid = busWriteData;
         end else if (regOff == etg_pkg::OFF_SEED_HIGH) begin
            next_r.seedHigh = busWriteData;
         end
      end

      // register reads, unmapped offsets answer zero
      if (busRead && regHit) begin
         next_r.readValid = 1'b1;
         if (regOff == etg_pkg::OFF_PKT_TARGET) begin
            next_r.readData = r.pktTarget;
         end else if (regOff == etg_pkg::OFF_CONFIG) begin
            next_r.readData = {16'h0000, r.cfg};
         end else if (regOff == etg_pkg::OFF_CONTROL) begin
            next_r.readData = {29'h00000000, r.doneBit, r.stopBit, r.startBit};
         end else if (regOff == etg_pkg::OFF_SRC_LOW) begin
            next_r.readData = r.srcLow;
         end else if (regOff == etg_pkg::OFF_SRC_HIGH) begin
            next_r.readData = {16'h0000, r.srcHigh};
         end else if (regOff == etg_pkg::OFF_DST_LOW) begin
            next_r.readData = r.dstLow;
         end else if (regOff == etg_pkg::OFF_DST_HIGH) begin
            next_r.readData = {16'h0000, r.dstHigh};
         end else if (regOff == etg_pkg::OFF_SENT_COUNT) begin
            next_r.readData = r.sentCount;
         end else if (regOff == etg_pkg::OFF_SEED_LOW) begin
            next_r.readData = r.seedLow;
         end else if (regOff == etg_pkg::OFF_SEED_MID) begin
            next_r.readData = r.seedMid;
         end else if (regOff == etg_pkg::OFF_SEED_HIGH) begin
            next_r.readData = r.seedHigh;
         end else begin
            next_r.readData = etg_pkg::RESET_WORD;
         end
      end

      // frame builder
      case (r.state)
         etg_pkg::ST_IDLE: begin
            if (r.startBit) begin
               next_r.startBit  = 1'b0;
               next_r.madeCount = etg_pkg::RESET_WORD;
               next_r.seqNum    = 16'h0000;
               if (r.pktTarget == etg_pkg::RESET_WORD) begin
                  next_r.doneBit = 1'b1;
               end else begin
                  next_r.prng = {r.seedHigh[etg_pkg::SEED_HIGH_USE-1:0],
                                 r.seedMid, r.seedLow};
                  next_r.payloadLen = frameLen(r.cfg, next_r.prng);
                  next_r.byteIdx = 14'h0000;
                  next_r.incByte = 8'h00;
                  next_r.crc     = etg_pkg::CRC_INIT;
                  next_r.state   = etg_pkg::ST_HEAD;
               end
            end
         end
         etg_pkg::ST_HEAD: begin
            if (pushOk) begin
               next_r.crc     = crcByte(r.crc, curByte);
               next_r.byteIdx = r.byteIdx + 14'h0001;
               if (r.byteIdx == etg_pkg::HEAD_LAST) begin
                  next_r.byteIdx = 14'h0000;
                  next_r.state   = (r.payloadLen == 14'h0000) ? etg_pkg::ST_TAIL
                                                              : etg_pkg::ST_BODY;
               end
            end
         end
         etg_pkg::ST_BODY: begin
            if (pushOk) begin
               next_r.crc     = crcByte(r.crc, curByte);
               next_r.prng    = prngStep(r.prng);
               next_r.incByte = r.incByte + 8'h01;
               next_r.byteIdx = r.byteIdx + 14'h0001;
               if (r.byteIdx == r.payloadLen - 14'h0001) begin
                  next_r.byteIdx = 14'h0000;
                  next_r.state   = etg_pkg::ST_TAIL;
               end
            end
         end
         etg_pkg::ST_TAIL: begin
            if (pushOk) begin
               next_r.byteIdx = r.byteIdx + 14'h0001;
               if (curEop) begin
                  next_r.madeCount  = r.madeCount + 32'h0000_0001;
                  next_r.seqNum     = r.seqNum + 16'h0001;
                  next_r.byteIdx    = 14'h0000;
                  next_r.incByte    = 8'h00;
                  next_r.crc        = etg_pkg::CRC_INIT;
                  next_r.prng       = prngStep(r.prng);
                  next_r.payloadLen = frameLen(r.cfg, r.prng);
                  if (lastFrame) begin
                     next_r.doneBit = 1'b1;
                     next_r.stopBit = 1'b0;
                     next_r.state   = etg_pkg::ST_IDLE;
                  end else if (r.stopBit || next_r.stopBit) begin
                     next_r.stopBit = 1'b0;
                     next_r.state   = etg_pkg::ST_IDLE;
                  end else begin
                     next_r.state = etg_pkg::ST_HEAD;
                  end
               end
            end
         end
         default: begin
            next_r.state = etg_pkg::ST_IDLE;
         end
      endcase

      // output stage toward the MAC
      if (drainIf.valid && drainIf.ready) begin
         next_r.txValid = 1'b1;
         next_r.txSop   = drainIf.data[9];
         next_r.txEop   = drainIf.data[8];
         next_r.txData  = drainIf.data[7:0];
      end else if (txReady) begin
         next_r.txValid = 1'b0;
      end

      // a start write in the same cycle wins over counting
      if (r.txValid && txReady && r.txEop && !next_r.startBit) begin
         next_r.sentCount = r.sentCount + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign busReadData  = r.readData;
   assign busReadValid = r.readValid;
   assign txData       = r.txData;
   assign txValid      = r.txValid;
   assign txSop        = r.txSop;
   assign txEop        = r.txEop;

endmodule
`default_nettype wire

// *** common/etg_pkg.sv ***
package etg_pkg;

   // component placement and register offsets
   localparam logic [31:0] BASE_ADDR      = 32'h0000_0C00;
   localparam int          OFFSET_BITS    = 6;
   localparam logic [5:0]  OFF_PKT_TARGET = 6'h00;
   localparam logic [5:0]  OFF_CONFIG     = 6'h04;
   localparam logic [5:0]  OFF_CONTROL    = 6'h08;
   localparam logic [5:0]  OFF_SRC_LOW    = 6'h10;
   localparam logic [5:0]  OFF_SRC_HIGH   = 6'h14;
   localparam logic [5:0]  OFF_DST_LOW    = 6'h18;
   localparam logic [5:0]  OFF_DST_HIGH   = 6'h1C;
   localparam logic [5:0]  OFF_SENT_COUNT = 6'h24;
   localparam logic [5:0]  OFF_SEED_LOW   = 6'h30;
   localparam logic [5:0]  OFF_SEED_MID   = 6'h34;
   localparam logic [5:0]  OFF_SEED_HIGH  = 6'h38;

   // field positions
   localparam int CFG_LEN_SEL   = 0;
   localparam int CFG_SIZE_LSB  = 1;
   localparam int CFG_SIZE_MSB  = 14;
   localparam int CFG_PATTERN   = 15;
   localparam int CFG_WIDTH     = 16;
   localparam int MAC_HIGH_BITS = 16;
   localparam int SEED_HIGH_USE = 28;
   localparam int CTL_START     = 0;
   localparam int CTL_STOP      = 1;
   localparam int CTL_DONE      = 2;

   // reset values
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // frame layout
   localparam int           SIZE_BITS     = 14;
   localparam logic [13:0]  SIZE_OVERHEAD = 14'h0018;
   localparam logic [13:0]  HEAD_LAST     = 14'h000F;
   localparam logic [13:0]  TAIL_LAST     = 14'h0003;
   localparam int           RAND_LEN_BITS = 10;
   localparam int           BYTE_BITS     = 8;
   localparam int           WORD_BITS     = 10;
   localparam int           FIFO_DEPTH    = 8;

   // checksum and pseudo-random generator
   localparam logic [31:0] CRC_INIT  = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY  = 32'hEDB8_8320;
   localparam int          PRNG_BITS = 92;
   localparam int          PRNG_TAP0 = 91;
   localparam int          PRNG_TAP1 = 90;
   localparam int          PRNG_TAP2 = 79;
   localparam int          PRNG_TAP3 = 78;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HEAD = 2'b01,
      ST_BODY = 2'b11,
      ST_TAIL = 2'b10
   } etg_state_type;

endpackage

// *** common/etg_stream_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface etg_stream_if #(parameter int WIDTH = 10) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/etg_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module etg_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic     clk,     // design clock
   input  wire logic     arst_n,  // async reset, active low
   etg_stream_if.sink    inPort,  // filling side
   etg_stream_if.source  outPort  // draining side
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wrPtr;
      logic [PW:0]                 rdPtr;
   } etg_fifo_type;

   etg_fifo_type r;
   etg_fifo_type next_r;
   logic         full;
   logic         empty;

   assign empty = (r.wrPtr == r.rdPtr);
   assign full  = (r.wrPtr[PW] != r.rdPtr[PW]) && (r.wrPtr[PW-1:0] == r.rdPtr[PW-1:0]);
   assign inPort.ready  = !full;
   assign outPort.valid = !empty;
   assign outPort.data  = r.mem[r.rdPtr[PW-1:0]];

   always_comb begin
      next_r = r;
      if (inPort.valid && !full) begin
         next_r.mem[r.wrPtr[PW-1:0]] = inPort.data;
         next_r.wrPtr = r.wrPtr + 1'b1;
      end
      if (outPort.ready && !empty) begin
         next_r.rdPtr = r.rdPtr + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule
`default_nettype wire

// *** test/etg_generator_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module etg_checker (
   input wire logic        clk,          // clock
   input wire logic        arst_n,       // reset
   input wire logic [31:0] busAddr,      // address
   input wire logic        busWrite,     // write strobe
   input wire logic [31:0] busWriteData, // write data
   input wire logic        busRead,      // read strobe
   input wire logic [31:0] busReadData,  // read data
   input wire logic        busReadValid, // read answer
   input wire logic [7:0]  txData,       // byte
   input wire logic        txValid,      // byte valid
   input wire logic        txSop,        // first byte
   input wire logic        txEop,        // last byte
   input wire logic        txReady       // sink ready
);
   wire logic             hit = busAddr[31:6] == etg_pkg::BASE_ADDR[31:6];
   wire logic [5:0]       off = busAddr[5:0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   chk_read_answer: assert property (busRead && hit |=> busReadValid)
      else $error("read in window not answered");
   chk_no_stray: assert property (!(busRead && hit) |=> !busReadValid)
      else $error("read answer without request");
   chk_reset_quiet: assert property (!$past(arst_n) |-> !txValid && !busReadValid)
      else $error("outputs active just after reset");
   chk_ctl_reserved: assert property (busRead && hit && off == 6'h08 |=> busReadData[31:3] == 29'h0)
      else $error("control reserved bits not zero");
   chk_cfg_reserved: assert property (busRead && hit && off == 6'h04 |=> busReadData[31:16] == 16'h0)
      else $error("config reserved bits not zero");
   chk_mac_high: assert property (busRead && hit && (off == 6'h14 || off == 6'h1C)
      |=> busReadData[31:16] == 16'h0)
      else $error("address high word upper half not zero");
   chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable({txData, txSop, txEop}))
      else $error("stalled byte changed");
   chk_eop_then_sop: assert property (txValid && txReady && txEop |=> !txValid || txSop)
      else $error("frame did not start with first byte");
   chk_min_frame: assert property (txValid && txReady && txSop |-> !txEop ##1 !(txValid && txEop) [*8])
      else $error("frame too short");
endmodule
bind etg_generator etg_checker etg_checker_inst (.clk(clk), .arst_n(arst_n), .busAddr(busAddr),
   .busWrite(busWrite), .busWriteData(busWriteData), .busRead(busRead),
   .busReadData(busReadData), .busReadValid(busReadValid), .txData(txData),
   .txValid(txValid), .txSop(txSop), .txEop(txEop), .txReady(txReady));
`default_nettype wire

// *** test/etg_mac_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module etg_mac_model (
   input  wire logic clk,     // clock
   input  wire logic arst_n,  // reset
   input  wire logic stallEn, // random back-pressure
   output var logic  txReady  // byte accepted
);
   int seed = 68315;
   initial txReady = 1'b0;
   always @(negedge clk) begin
      txReady <= arst_n && (!stallEn || $random(seed) % 3 != 0);
   end
endmodule
`default_nettype wire

// *** test/etg_generator_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module etg_generator_tb;
   localparam logic [31:0] B = etg_pkg::BASE_ADDR;
   logic        clk, arst_n, busWrite, busRead, busReadValid, txValid, txSop, txEop, txReady;
   logic        stallEn;
   logic [31:0] busAddr, busWriteData, busReadData, dstLo, dstHi, srcLo, srcHi;
   logic [91:0] prng;
   bit          rndPay;
   logic [7:0]  txData;
   logic [31:0] rdQ[$];
   logic [9:0]  txQ[$];
   logic [5:0]  offs[10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h24, 6'h34};
   int          failures, nTests, cyc, seed;
   etg_generator etg_generator_inst (.clk(clk), .arst_n(arst_n), .busAddr(busAddr),
      .busWrite(busWrite), .busWriteData(busWriteData), .busRead(busRead),
      .busReadData(busReadData), .busReadValid(busReadValid), .txData(txData),
      .txValid(txValid), .txSop(txSop), .txEop(txEop), .txReady(txReady));
   etg_mac_model etg_mac_model_inst (.clk(clk), .arst_n(arst_n), .stallEn(stallEn),
      .txReady(txReady));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] off, input logic [31:0] d);
      @(negedge clk);
      busAddr = B + off;
      busWrite = 1'b1;
      busWriteData = d;
      @(negedge clk);
      busWrite = 1'b0;
   endtask
   // outside the 64-byte window no answer is expected
   task automatic rd(input logic [31:0] off, input logic [31:0] exp);
      @(negedge clk);
      busAddr = B + off;
      busRead = 1'b1;
      if (off < 32'h40) rdQ.push_back(exp);
      @(negedge clk);
      busRead = 1'b0;
   endtask
   function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
      logic [31:0] r;
      r = c ^ {24'h0, b};
      for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ etg_pkg::CRC_POLY : r >> 1;
      return r;
   endfunction
   task automatic frame(input logic [15:0] seq, input logic [15:0] n);
      logic [7:0]  f[$];
      logic [31:0] c;
      f = {dstLo[7:0], dstLo[15:8], dstLo[23:16], dstLo[31:24], dstHi[7:0], dstHi[15:8],
           srcLo[7:0], srcLo[15:8], srcLo[23:16], srcLo[31:24], srcHi[7:0], srcHi[15:8],
           n[15:8], n[7:0], seq[15:8], seq[7:0]};
      // random payload byte is the low byte, then eight left shifts of the 92-bit source
      for (int i = 0; i < n; i++) begin
         f.push_back(rndPay ? prng[7:0] : i[7:0]);
         repeat (8) prng = {prng[90:0], prng[91] ^ prng[90] ^ prng[79] ^ prng[78]};
      end
      c = 32'hFFFF_FFFF;
      foreach (f[i]) c = crcByte(c, f[i]);
      c = ~c;
      f = {f, c[7:0], c[15:8], c[23:16], c[31:24]};
      foreach (f[i]) txQ.push_back({i == 0, i == f.size() - 1, f[i]});
   endtask
   task automatic drain();
      for (int i = 0; i < 3000 && txQ.size() > 0; i++) @(negedge clk);
      repeat (4) @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 8000) begin
         failures++;
         test_done();
      end
      if (busReadValid) chk("read", busReadData, rdQ.size() ? rdQ.pop_front() : 'x);
      if (txValid && txReady)
         chk("tx", {22'h0, txSop, txEop, txData}, txQ.size() ? {22'h0, txQ.pop_front()} : 'x);
   end
   initial begin
      seed = 68315;
      {failures, nTests, cyc} = '0;
      {arst_n, busWrite, busRead, stallEn, busAddr, busWriteData} = '0;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      foreach (offs[i]) rd({26'h0, offs[i]}, 32'h0);
      $display("test reset values done");
      wr(32'h04, 32'hFFFF_FFFF);
      rd(32'h04, 32'h0000_FFFF);
      wr(32'h14, 32'hFFFF_FFFF);
      rd(32'h14, 32'h0000_FFFF);
      wr(32'h34, 32'h1234_5678);
      rd(32'h34, 32'h1234_5678);
      wr(32'h0C, 32'hFFFF_FFFF);
      rd(32'h0C, 32'h0);
      wr(32'h08, 32'h2);
      rd(32'h08, 32'h0);
      rd(32'h400, 32'h0);
      wr(32'h34, 32'h0);
      $display("test register access done");
      {dstLo, dstHi, srcLo, srcHi} = {$random(seed), $random(seed), $random(seed), $random(seed)};
      wr(32'h10, srcLo);
      wr(32'h14, srcHi);
      wr(32'h18, dstLo);
      wr(32'h1C, dstHi);
      wr(32'h00, 32'h2);
      wr(32'h04, 32'h34);
      stallEn = 1'b1;
      frame(16'h0, 16'h2);
      frame(16'h1, 16'h2);
      wr(32'h08, 32'h1);
      drain();
      rd(32'h08, 32'h4);
      rd(32'h24, 32'h2);
      $display("test fixed run done");
      wr(32'h00, 32'h5);
      wr(32'h04, 32'h30);
      frame(16'h0, 16'h0);
      wr(32'h08, 32'h1);
      for (int i = 0; i < 50 && !txValid; i++) @(negedge clk);
      wr(32'h08, 32'h2);
      drain();
      rd(32'h24, 32'h1);
      rd(32'h08, 32'h0);
      $display("test stop done");
      wr(32'h00, 32'h1);
      wr(32'h04, 32'h8001);
      wr(32'h30, 32'hA5C3_0005);
      wr(32'h34, 32'h1234_5678);
      wr(32'h38, 32'hF000_0001);
      {rndPay, prng} = {1'b1, 28'h000_0001, 32'h1234_5678, 32'hA5C3_0005};
      frame(16'h0, 16'h5);
      wr(32'h08, 32'h1);
      drain();
      rd(32'h08, 32'h4);
      wr(32'h00, 32'h0);
      wr(32'h08, 32'h1);
      repeat (4) @(negedge clk);
      rd(32'h08, 32'h4);
      rd(32'h24, 32'h0);
      $display("test random and empty runs done");
      repeat (4) @(negedge clk);
      chk("pending", txQ.size() + rdQ.size(), 32'h0);
      test_done();
   end
endmodule
`default_nettype wire
